/* File: cpu_core_pkg.sv */
// Constants, encodings and address map of the fetch pipeline and data planes
package cpu_core_pkg;
   localparam int PC_W = 12; // program counter width
   localparam int IW = 14; // instruction word width
   localparam int DW = 8; // data width
   localparam int AW = 8; // data plane address width
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] WORK_RESET = 8'h00;
   // General plane map
   localparam logic [7:0] GEN_INDIRECT_ADDR = 8'h00;
   localparam logic [7:0] GEN_FILE_PTR_ADDR = 8'h04;
   localparam logic [7:0] AUX_PTR_ADDR = 8'h07;
   localparam logic [7:0] GEN_RAM_BASE = 8'h10;
   localparam logic [7:0] GEN_BIT_LIMIT = 8'h80;
   // Auxiliary plane map
   localparam logic [7:0] AUX_INDIRECT_ADDR = 8'h00;
   localparam logic [7:0] AUX_RO_PC_LO = 8'h01;
   localparam logic [7:0] AUX_RO_PC_HI = 8'h02;
   localparam logic [7:0] AUX_RO_TOP = 8'h3f;
   localparam logic [7:0] AUX_SEG_BASE = 8'h40;
   localparam logic [7:0] AUX_SEG_TOP = 8'h5f;
   localparam logic [7:0] AUX_RAM_BASE = 8'h60;
   // Instruction classes in bits 13:12
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_CALL = 2'h3;
   // Byte operations in bits 11:8
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_ADD_WORKING_TO_FILE = 4'h1;
   localparam logic [3:0] OP_INCREMENT_FILE = 4'h2;
   localparam logic [3:0] OP_COPY_WORKING_TO_FILE = 4'h3;
   localparam logic [3:0] OP_COPY_FILE_TO_WORKING = 4'h4;
   localparam logic [3:0] OP_COPY_WORKING_TO_AUX = 4'h5;
   localparam logic [3:0] OP_COPY_AUX_TO_WORKING = 4'h6;
   // Bit operations in bits 11:10, bit number 9:7, address 6:0
   localparam logic [1:0] BOP_SET = 2'h0;
   localparam logic [1:0] BOP_CLEAR = 2'h1;
   localparam logic [1:0] BOP_TEST_SKIP_CLEAR = 2'h2;
   localparam logic [1:0] BOP_LOAD_LITERAL = 2'h3;
   typedef enum logic {FIRST_PHASE, SECOND_PHASE} phase_t;
endpackage

/* File: plane_mem.sv */
// Single-port data plane memory with registered read data
`timescale 1ns/100ps
module plane_mem
   import cpu_core_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 8
)
(
   input wire logic core_clk, // system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic rd_en, // capture read data
   input wire logic wr_en, // write strobe
   input wire logic [ADDR_W-1:0] addr, // word address
   input wire logic [DATA_W-1:0] wdata, // write data
   output logic [DATA_W-1:0] rdata // registered read data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rdata_reg;

   assign rdata = rdata_reg;

   // Storage, no reset so it maps onto RAM
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         mem[addr] <= wdata;
      end
   end

   // Read port
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rdata_reg <= '0;
      end
      else if (rd_en)
      begin
         rdata_reg <= mem[addr];
      end
   end
endmodule // plane_mem

/* File: cpu_fetch_pipeline.sv */
// Two-phase fetch/execute pipeline with general and auxiliary data planes
`timescale 1ns/100ps
module cpu_fetch_pipeline
   import cpu_core_pkg::*;
(
   input wire logic core_clk, // 50 MHz system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [IW-1:0] rom_data, // program word at rom_addr
   output logic [PC_W-1:0] rom_addr, // program counter
   output logic first_phase, // high during first phase
   output logic second_phase, // high during second phase
   output logic [DW-1:0] working_out // working register
);
   phase_t phase_reg;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [IW-1:0] ir_reg;
   logic ir_valid_reg;
   logic [DW-1:0] w_reg, w_next;
   logic [DW-1:0] gfp_reg, gfp_next;
   logic [DW-1:0] app_reg, app_next;
   logic first_phase_reg, second_phase_reg;

   // Resolve a port address through its pointer; used for both planes
   function automatic logic [7:0] resolve(input logic [7:0] addr, input logic [7:0] port,
                                          input logic [7:0] ptr);
      resolve = (addr == port) ? ptr : addr;
   endfunction

   // Instruction fields
   wire logic [1:0] cls = ir_reg[13:12];
   wire logic [3:0] bop = ir_reg[11:8];
   wire logic [1:0] bitop = ir_reg[11:10];
   wire logic [2:0] bit_no = ir_reg[9:7];
   wire logic [7:0] literal = ir_reg[7:0];
   wire logic [7:0] byte_addr = ir_reg[7:0];
   wire logic [7:0] bit_addr = {1'b0, ir_reg[6:0]};
   wire logic is_first = (phase_reg == FIRST_PHASE);
   wire logic is_second = (phase_reg == SECOND_PHASE);
   wire logic exec = ir_valid_reg;

   // Decoded operations
   wire logic is_byte = exec && (cls == CLS_BYTE);
   wire logic is_bit = exec && (cls == CLS_BIT);
   wire logic do_add = is_byte && (bop == OP_ADD_WORKING_TO_FILE);
   wire logic do_inc = is_byte && (bop == OP_INCREMENT_FILE);
   wire logic do_cwf = is_byte && (bop == OP_COPY_WORKING_TO_FILE);
   wire logic do_cfw = is_byte && (bop == OP_COPY_FILE_TO_WORKING);
   wire logic do_cwa = is_byte && (bop == OP_COPY_WORKING_TO_AUX);
   wire logic do_caw = is_byte && (bop == OP_COPY_AUX_TO_WORKING);
   wire logic do_bset = is_bit && (bitop == BOP_SET);
   wire logic do_bclr = is_bit && (bitop == BOP_CLEAR);
   wire logic do_btst = is_bit && (bitop == BOP_TEST_SKIP_CLEAR);
   wire logic do_lit = is_bit && (bitop == BOP_LOAD_LITERAL);
   wire logic do_jump = exec && ((cls == CLS_JUMP) || (cls == CLS_CALL));

   // General plane effective address: direct, or through the file pointer
   wire logic [7:0] gen_direct = is_bit ? bit_addr : byte_addr;
   wire logic [7:0] gen_eff = resolve(gen_direct, GEN_INDIRECT_ADDR, gfp_reg);
   wire logic gen_is_port = (gen_eff == GEN_INDIRECT_ADDR);
   wire logic gen_is_sfr = (gen_eff < GEN_RAM_BASE);
   // Pointer may reach the upper half; bit access there is refused
   wire logic bit_ok = (gen_eff < GEN_BIT_LIMIT);
   wire logic gen_uses = do_add || do_inc || do_cwf || do_cfw || ((do_bset || do_bclr || do_btst) && bit_ok);
   wire logic gen_writes = do_add || do_inc || do_cwf || ((do_bset || do_bclr) && bit_ok);

   // Auxiliary plane effective address through its pointer
   wire logic [7:0] aux_eff = resolve(byte_addr, AUX_INDIRECT_ADDR, app_reg);
   wire logic aux_is_ro = (aux_eff <= AUX_RO_TOP);
   wire logic aux_is_mem = (aux_eff >= AUX_SEG_BASE);

   // Memory strobes: read captured at end of first phase, write at end of second
   wire logic gen_rd = is_first && gen_uses && !gen_is_sfr;
   wire logic gen_wr = is_second && gen_writes && !gen_is_sfr;
   wire logic aux_rd = is_first && do_caw && aux_is_mem;
   wire logic aux_wr = is_second && do_cwa && aux_is_mem;
   logic [DW-1:0] gen_rdata, aux_rdata;

   // Special registers read back; the port itself has no storage
   wire logic [DW-1:0] sfr_rdata =
      gen_is_port ? 8'h00 :
      (gen_eff == GEN_FILE_PTR_ADDR) ? gfp_reg :
      (gen_eff == AUX_PTR_ADDR) ? app_reg : 8'h00;
   wire logic [DW-1:0] gen_val = gen_is_sfr ? sfr_rdata : gen_rdata;
   wire logic [DW-1:0] aux_ro_val =
      (aux_eff == AUX_RO_PC_LO) ? pc_reg[7:0] :
      (aux_eff == AUX_RO_PC_HI) ? {4'h0, pc_reg[11:8]} : 8'h00;
   wire logic [DW-1:0] aux_val = aux_is_ro ? aux_ro_val : aux_rdata;

   // Result of a general plane operation
   wire logic [DW-1:0] bit_mask = 8'h01 << bit_no;
   wire logic [DW-1:0] gen_result =
      do_add ? 8'(gen_val + w_reg) :
      do_inc ? 8'(gen_val + 8'h01) :
      do_cwf ? w_reg :
      do_bset ? (gen_val | bit_mask) :
      (gen_val & ~bit_mask);
   wire logic skip = do_btst && bit_ok && ((gen_val & bit_mask) == 8'h00);
   wire logic taken = do_jump || skip;

   plane_mem #(.DATA_W(DW), .ADDR_W(AW)) u_general_plane
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rd_en(gen_rd),
      .wr_en(gen_wr),
      .addr(gen_eff),
      .wdata(gen_result),
      .rdata(gen_rdata)
   );

   plane_mem #(.DATA_W(DW), .ADDR_W(AW)) u_aux_plane
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rd_en(aux_rd),
      .wr_en(aux_wr),
      .addr(aux_eff),
      .wdata(w_reg),
      .rdata(aux_rdata)
   );

   // Next values, committed only at the end of the second phase
   always_comb
   begin
      pc_next = pc_reg + 12'h001;
      w_next = w_reg;
      gfp_next = gfp_reg;
      app_next = app_reg;
      if (do_jump)
      begin
         pc_next = ir_reg[11:0];
      end
      if (do_cfw)
      begin
         w_next = gen_val;
      end
      else if (do_caw)
      begin
         w_next = aux_val;
      end
      else if (do_lit)
      begin
         w_next = literal;
      end
      if (gen_writes && (gen_eff == GEN_FILE_PTR_ADDR))
      begin
         gfp_next = gen_result;
      end
      if (gen_writes && (gen_eff == AUX_PTR_ADDR))
      begin
         app_next = gen_result;
      end
   end

   // Phase divider: each instruction cycle is two system clocks
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         phase_reg <= FIRST_PHASE;
         first_phase_reg <= 1'b1;
         second_phase_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= is_first ? SECOND_PHASE : FIRST_PHASE;
         first_phase_reg <= is_second;
         second_phase_reg <= is_first;
      end
   end

   // Program counter steps on entry to the first phase
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pc_reg <= RESET_VECTOR;
      end
      else if (is_second)
      begin
         pc_reg <= pc_next;
      end
   end

   // Word latched at end of second phase; killed when the executing one branches
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ir_reg <= '0;
         ir_valid_reg <= 1'b0;
      end
      else if (is_second)
      begin
         ir_reg <= rom_data;
         ir_valid_reg <= !taken;
      end
   end

   // Architectural registers commit with the second phase
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         w_reg <= WORK_RESET;
         gfp_reg <= PTR_RESET;
         app_reg <= PTR_RESET;
      end
      else if (is_second)
      begin
         w_reg <= w_next;
         gfp_reg <= gfp_next;
         app_reg <= app_next;
      end
   end

   assign rom_addr = pc_reg;
   assign first_phase = first_phase_reg;
   assign second_phase = second_phase_reg;
   assign working_out = w_reg;
endmodule // cpu_fetch_pipeline

/* File: prog_rom.sv */
// Program ROM model on the far side of the fetch port
`timescale 1ns/100ps
module prog_rom
   import cpu_core_pkg::*;
(
   input wire logic [PC_W-1:0] rom_addr, // word address
   output logic [IW-1:0] rom_data // program word
);
   logic [IW-1:0] mem [0:4095];
   // Read with no delay; the core samples at the end of its second phase
   assign rom_data = mem[rom_addr];
endmodule // prog_rom

/* File: cpu_fetch_pipeline_props.sv */
// Port assertions for the fetch pipeline
`timescale 1ns/100ps
module cpu_fetch_pipeline_props
   import cpu_core_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset
   input wire logic [IW-1:0] rom_data, // word
   input wire logic [PC_W-1:0] rom_addr, // pc
   input wire logic first_phase, // phase one
   input wire logic second_phase, // phase two
   input wire logic [DW-1:0] working_out // W
);
   logic [1:0] cls_reg;
   // Class of executing word; only byte ops surely never redirect fetch
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         cls_reg <= CLS_BYTE;
      else if (second_phase)
         cls_reg <= rom_data[13:12];
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // Fetches that are sure to execute
   sequence s_safe;
      second_phase && cls_reg == CLS_BYTE;
   endsequence
   sequence s_jump;
      s_safe ##0 rom_data[13];
   endsequence
   sequence s_lit;
      s_safe ##0 rom_data[13:10] == {CLS_BIT, BOP_LOAD_LITERAL};
   endsequence
   // Sampled reset in the antecedent keeps the release edge, still in reset state, out
   property p_toggle;
      rst_n && first_phase |=> !first_phase && second_phase ##1 first_phase && !second_phase;
   endproperty
   a_toggle: assert property (p_toggle) else $error("phase order");
   property p_pc_hold;
      first_phase |=> $stable(rom_addr);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved early");
   property p_pc_step;
      s_safe |=> rom_addr == $past(rom_addr) + 12'h001;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc step");
   property p_jump;
      s_jump |=> ##2 rom_addr == $past(rom_data[11:0], 3);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target");
   property p_flush;
      s_jump |=> ##1 $stable(working_out) [*4];
   endproperty
   a_flush: assert property (p_flush) else $error("flushed slot acted");
   property p_lit;
      s_lit |=> ##2 working_out == $past(rom_data[7:0], 3);
   endproperty
   a_lit: assert property (p_lit) else $error("literal result");
   property p_w_edge;
      !$stable(working_out) && $past(rst_n) |-> $past(second_phase);
   endproperty
   a_w_edge: assert property (p_w_edge) else $error("W changed mid cycle");
   property p_reset;
      disable iff (1'b0) !rst_n |=> rom_addr == RESET_VECTOR && first_phase && working_out == WORK_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
endmodule // cpu_fetch_pipeline_props
bind cpu_fetch_pipeline cpu_fetch_pipeline_props props_i (.core_clk(core_clk), .rst_n(rst_n),
   .rom_data(rom_data), .rom_addr(rom_addr), .first_phase(first_phase), .second_phase(second_phase),
   .working_out(working_out));

/* File: cpu_fetch_pipeline_and_data_planes_tb.sv */
// Random short programs run from reset; W read once each program loops
`timescale 1ns/100ps
module cpu_fetch_pipeline_and_data_planes_tb;
   import cpu_core_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [IW-1:0] rom_data;
   logic [PC_W-1:0] rom_addr;
   logic first_phase;
   logic second_phase;
   logic [DW-1:0] working_out;
   logic [7:0] v1, v2, a, x, m, p, y;
   logic [11:0] t;
   logic [2:0] b;
   int bad_count = 0;
   int n_checks = 0;
   int pc;
   cpu_fetch_pipeline DUT (.core_clk(core_clk), .rst_n(rst_n), .rom_data(rom_data), .rom_addr(rom_addr),
      .first_phase(first_phase), .second_phase(second_phase), .working_out(working_out));
   prog_rom rom (.rom_addr(rom_addr), .rom_data(rom_data));
   // 50 MHz clock
   initial
   begin
      forever #10 core_clk = ~core_clk;
   end
   // Encoders: literal load and byte operation
   function automatic logic [13:0] lit(input logic [7:0] v);
      return {CLS_BIT, BOP_LOAD_LITERAL, 2'h0, v};
   endfunction
   function automatic logic [13:0] f(input logic [3:0] op, input logic [7:0] ad);
      return {CLS_BYTE, op, ad};
   endfunction
   task automatic put(input logic [13:0] w);
      rom.mem[pc] = w;
      pc++;
   endtask
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Reset lands first, so ROM rewrites never race a live fetch
   task automatic start();
      @(posedge core_clk);
      rst_n <= 1'b0;
      #1;
      for (int i = 0; i < 4096; i++)
         rom.mem[i] = '0;
      pc = 0;
   endtask
   // Close with a jump to itself, release reset, read W once looping
   task automatic run(input logic [7:0] exp_w);
      int n;
      int e;
      e = pc;
      put({CLS_JUMP, 12'(e)});
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      check(rom_addr, RESET_VECTOR);
      check({10'h000, first_phase, second_phase}, 12'h002);
      @(posedge core_clk);
      #1;
      check({10'h000, first_phase, second_phase}, 12'h001);
      n = 0;
      // Look after the edge has settled, never in its own time step
      while (rom_addr !== 12'(e) && n < 1000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (rom_addr !== 12'(e))
      begin
         bad_count++;
         wrap_up();
      end
      repeat (6) @(posedge core_clk);
      #1;
      check({4'h0, working_out}, {4'h0, exp_w});
   endtask
   // First pass uses the top file address and top program word
   initial
   begin
      void'($urandom(2409));
      for (int k = 0; k < 4; k++)
      begin
         v1 = 8'($urandom);
         v2 = 8'($urandom);
         a = k == 0 ? 8'hff : 8'h10 + 8'($urandom % 240);
         x = 8'h10 + 8'($urandom % 112);
         p = 8'h40 + 8'($urandom % 192);
         t = k == 0 ? 12'hfff : 12'h040 + 12'($urandom % 4032);
         b = 3'($urandom);
         m = 8'h01 << b;
         start();
         put(lit(v1));
         put(f(OP_COPY_WORKING_TO_FILE, a));
         put(lit(v2));
         put(f(OP_ADD_WORKING_TO_FILE, a));
         put(f(OP_INCREMENT_FILE, a));
         put(lit(a));
         put(f(OP_COPY_WORKING_TO_FILE, GEN_FILE_PTR_ADDR));
         put(f(OP_COPY_FILE_TO_WORKING, GEN_INDIRECT_ADDR));
         run(v1 + v2 + 8'h01);
         start();
         put(lit(p));
         put(f(OP_COPY_WORKING_TO_FILE, AUX_PTR_ADDR));
         put(lit(v1));
         put(f(OP_COPY_WORKING_TO_AUX, AUX_INDIRECT_ADDR));
         put(lit(v2));
         put(f(OP_COPY_WORKING_TO_FILE, p));
         put(f(OP_COPY_WORKING_TO_AUX, AUX_RO_TOP));
         put(f(OP_COPY_AUX_TO_WORKING, AUX_RO_TOP));
         put(f(OP_COPY_WORKING_TO_FILE, 8'h20));
         put(f(OP_COPY_AUX_TO_WORKING, p));
         put(f(OP_ADD_WORKING_TO_FILE, 8'h20));
         put(f(OP_COPY_FILE_TO_WORKING, 8'h20));
         run(v1);
         for (int j = 0; j < 3; j++)
         begin
            start();
            put(lit(j == 0 ? 8'h00 : j == 1 ? 8'hff : ~m));
            put(f(OP_COPY_WORKING_TO_FILE, x));
            put(lit(m));
            put({CLS_BIT, 2'(j), b, x[6:0]});
            put(f(OP_COPY_FILE_TO_WORKING, x));
            run(j == 1 ? ~m : m);
         end
         // Upper half reached through the pointer refuses a bit set
         y = 8'h80 + 8'($urandom % 128);
         start();
         put(lit(8'h00));
         put(f(OP_COPY_WORKING_TO_FILE, y));
         put(lit(y));
         put(f(OP_COPY_WORKING_TO_FILE, GEN_FILE_PTR_ADDR));
         put({CLS_BIT, BOP_SET, b, 7'h00});
         put(f(OP_COPY_FILE_TO_WORKING, GEN_INDIRECT_ADDR));
         run(8'h00);
         start();
         put(lit(v1));
         put(f(OP_COPY_WORKING_TO_FILE, a));
         put({CLS_JUMP, t});
         put(lit(~v1));
         pc = int'(t);
         run(v1);
      end
      wrap_up();
   end
endmodule // cpu_fetch_pipeline_and_data_planes_tb
